// ==== hdl/iopst_pkg.sv ====
package iopst_pkg;

   // Clock rate of the system domain
   localparam int unsigned CLK_HZ = 50_000_000;

   // Register word addresses (even byte address of each 16-bit register)
   localparam logic [6:0] ADDR_AUX_DAC = 7'h30;
   localparam logic [6:0] ADDR_GPIO = 7'h32;
   localparam logic [6:0] ADDR_MSC = 7'h34;
   localparam logic [6:0] ADDR_SMPL = 7'h36;
   localparam logic [6:0] ADDR_SLP = 7'h3a;
   localparam logic [6:0] ADDR_DIAG = 7'h3c;
   localparam logic [6:0] ADDR_GLOB = 7'h3e;

   // Values after reset
   localparam logic [15:0] RST_SMPL = 16'h0001;
   localparam logic [15:0] RST_SLP = 16'h0000;
   localparam logic [15:0] RST_GPIO = 16'h0000;
   localparam logic [15:0] RST_MSC = 16'h0000;
   localparam logic [15:0] RST_DAC = 16'h0000;
   localparam logic [15:0] RST_DIAG = 16'h0000;

   // Writable bits of each register; the rest read as zero
   localparam logic [15:0] MASK_SMPL = 16'h00ff;
   localparam logic [15:0] MASK_SLP = 16'h00ff;
   localparam logic [15:0] MASK_GPIO = 16'h0303;
   localparam logic [15:0] MASK_MSC = 16'h0f07;
   localparam logic [15:0] MASK_DAC = 16'h0fff;

   // Field positions
   localparam int GPIO_DIR_LSB = 0;
   localparam int GPIO_LVL_LSB = 8;
   localparam int MSC_DR_SEL = 0;
   localparam int MSC_DR_POL = 1;
   localparam int MSC_DR_EN = 2;
   localparam int MSC_STIM_POS = 8;
   localparam int MSC_STIM_NEG = 9;
   localparam int MSC_SELF_TEST = 10;
   localparam int MSC_MEM_TEST = 11;
   localparam int GLOB_DAC_LATCH = 2;
   localparam int DIAG_SELF_FAIL = 5;
   localparam int DIAG_MEM_FAIL = 6;
   localparam int CMD_WRITE_BIT = 15;
   localparam int DAC_BITS = 12;

   // Low power threshold on the sample period low byte
   localparam logic [7:0] LOW_POWER_MIN = 8'h08;

   // Sleep weight per count and data ready pulse limits
   localparam int unsigned SLEEP_LSB_MS = 500;
   localparam int unsigned SLEEP_LSB_CYCLES = CLK_HZ / 1000 * SLEEP_LSB_MS;
   localparam int unsigned DR_MIN_US = 100;
   localparam int unsigned DR_MAX_US = 200;
   localparam int unsigned DR_MIN_CYCLES = (CLK_HZ / 1000000 * DR_MIN_US);
   localparam int unsigned DR_MAX_CYCLES = (CLK_HZ / 1000000 * DR_MAX_US);
   localparam int unsigned DR_WIDTH_CYCLES = (DR_MIN_CYCLES + DR_MAX_CYCLES) / 2;

   // Serial frame length
   localparam logic [3:0] SPI_LAST_BIT = 4'hf;

   typedef enum logic [1:0] {OWN_READY, OWN_ALARM, OWN_GENERAL} iopst_owner_e;

   // Alarm logic hand-in: enable, line select and polarised level
   typedef struct packed {
      logic enable;
      logic line_select;
      logic level;
   } iopst_alarm_s;

   // Completion report of a test routine
   typedef struct packed {
      logic done;
      logic fail;
   } iopst_test_s;

   typedef struct packed {
      logic [3:0] cnt;
      logic [14:0] shift;
      logic [15:0] word;
      logic tog;
   } iopst_link_s;

   typedef struct packed {
      logic link_rst;
      logic [1:0] tog_sync;
      logic tog_prev;
      logic [1:0] pin_sync0;
      logic [1:0] pin_sync1;
      logic [15:0] smpl;
      logic [15:0] slp;
      logic [15:0] gpio;
      logic [15:0] msc;
      logic [15:0] dac_buf;
      logic [11:0] dac;
      logic [15:0] diag;
      logic [15:0] rd;
      logic sleep;
      logic [7:0] slp_left;
      logic [24:0] slp_tick;
      logic [15:0] dr_cnt;
      logic [1:0] pin_o;
      logic [1:0] pin_oe;
   } iopst_state_s;

endpackage : iopst_pkg

// ==== hdl/iopst_spi_link.sv ====
`timescale 1ns/100ps

// Serial shifter on the link clock; idles high, samples on rising edges
module iopst_spi_link
   import iopst_pkg::*;
(
   input wire logic spi_sclk,
   input wire logic spi_rst,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   input wire logic [15:0] reply_word,
   output logic spi_miso,
   output logic [15:0] frame_word,
   output logic frame_toggle
);

   iopst_link_s l_q;
   iopst_link_s l_d;

   // Shift in one bit per edge; a full word flips the toggle
   always_comb
   begin
      l_d = l_q;
      if (!spi_cs_n)
      begin
         l_d.shift = {l_q.shift[13:0], spi_mosi};
         l_d.cnt = l_q.cnt + 4'h1;
         if (l_q.cnt == SPI_LAST_BIT)
         begin
            l_d.word = {l_q.shift, spi_mosi};
            l_d.tog = ~l_q.tog;
         end
      end
   end

   // Reset comes from a system flop, so it only ever loads constants
   always_ff @(posedge spi_sclk or posedge spi_rst)
   begin
      if (spi_rst)
         l_q <= '0;
      else
         l_q <= l_d;
   end

   // Reply word is held still by the system side for the whole frame
   assign spi_miso = reply_word[SPI_LAST_BIT - l_q.cnt];
   assign frame_word = l_q.word;
   assign frame_toggle = l_q.tog;

endmodule : iopst_spi_link

// ==== hdl/iopst_ctrl.sv ====
`timescale 1ns/100ps

module iopst_ctrl
   import iopst_pkg::*;
#(
   parameter int unsigned SLEEP_CYCLES = SLEEP_LSB_CYCLES,
   parameter logic [15:0] DR_WIDTH = 16'(DR_WIDTH_CYCLES)
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic spi_sclk,
   input wire logic spi_cs_n,
   input wire logic spi_mosi,
   output logic spi_miso,
   input wire logic sample_ready,
   input wire iopst_pkg::iopst_alarm_s alarm_configuration,
   input wire iopst_pkg::iopst_test_s memory_test,
   input wire iopst_pkg::iopst_test_s self_test,
   input wire logic [1:0] digital_line_i,
   output logic [1:0] digital_line_o,
   output logic [1:0] digital_line_oe,
   output logic memory_test_run,
   output logic self_test_run,
   output logic stimulus_negative,
   output logic stimulus_positive,
   output logic [11:0] dac_code,
   output logic low_power_mode,
   output logic sleep_mode
);

   import iopst_pkg::*;

   // All system-domain state lives in one packed struct
   iopst_state_s s_q;
   iopst_state_s s_d;

   // Received frame and the fields decoded from it
   logic [15:0] link_word;
   logic link_tog;
   logic frame_new;
   logic is_write;
   logic hi_byte;
   logic [6:0] reg_addr;
   logic [7:0] wr_data;
   logic dr_active;

   // Line ownership and the drive it asks for, before the pin register
   iopst_owner_e line_own [1:0];
   logic [1:0] pin_o_nx;
   logic [1:0] pin_oe_nx;

   // Pick which function owns a digital line
   function automatic iopst_owner_e line_owner(
      input logic line_two,
      input logic [15:0] msc,
      input iopst_alarm_s alm
   );
      iopst_owner_e own;
      own = OWN_GENERAL;
      if (msc[MSC_DR_EN] && (msc[MSC_DR_SEL] == line_two))
         own = OWN_READY;
      else if (alm.enable && (alm.line_select == line_two))
         own = OWN_ALARM;
      return own;
   endfunction : line_owner

   // Merge one written byte into a 16-bit register image
   function automatic logic [15:0] merge_byte(
      input logic [15:0] old,
      input logic [7:0] data,
      input logic hi
   );
      logic [15:0] res;
      res = hi ? {data, old[7:0]} : {old[15:8], data};
      return res;
   endfunction : merge_byte

   // Reply word of a read frame; unmapped addresses answer zero
   function automatic logic [15:0] read_value(
      input logic [6:0] addr,
      input iopst_state_s st
   );
      logic [15:0] val;
      val = 16'h0000;
      case (addr)
         ADDR_AUX_DAC:
            val = st.dac_buf;
         ADDR_GPIO:
         begin
            // Input lines report the synchronised pin, outputs the stored level
            val = st.gpio;
            for (int k = 0; k < 2; k++)
               if (!st.gpio[GPIO_DIR_LSB + k])
                  val[GPIO_LVL_LSB + k] = st.pin_sync1[k];
         end
         ADDR_MSC:
            val = st.msc;
         ADDR_SMPL:
            val = st.smpl;
         ADDR_SLP:
            val = st.slp;
         ADDR_DIAG:
            val = st.diag;
         ADDR_GLOB:
            val = 16'h0000;
         default:
            val = 16'h0000;
      endcase
      return val;
   endfunction : read_value

   // Link side shifter runs on the host's serial clock
   // Its reset is a system flop, released while the link clock stands idle
   iopst_spi_link u_link (
      .spi_sclk(spi_sclk),
      .spi_rst(s_q.link_rst),
      .spi_cs_n(spi_cs_n),
      .spi_mosi(spi_mosi),
      .reply_word(s_q.rd),
      .spi_miso(spi_miso),
      .frame_word(link_word),
      .frame_toggle(link_tog)
   );

   // Frame arrival; the word is stable long before the toggle lands here
   assign frame_new = s_q.tog_sync[1] ^ s_q.tog_prev;
   assign is_write = link_word[CMD_WRITE_BIT];
   // Bits 14:9 name the 16-bit word, bit 8 picks its byte
   assign reg_addr = {link_word[14:9], 1'b0};
   assign hi_byte = link_word[8];
   assign wr_data = link_word[7:0];

   // A running pulse counter holds the line at its active level
   assign dr_active = (s_q.dr_cnt != 16'h0000);

   // Per-line owner and the value the line should take
   generate
      for (genvar g = 0; g < 2; g++)
      begin : g_line
         logic oe_g;
         logic o_g;
         assign line_own[g] = line_owner(1'(g), s_q.msc, alarm_configuration);
         // Between pulses data ready shows its idle level, so each pulse has two edges
         always_comb
         begin
            case (line_own[g])
               OWN_READY:
               begin
                  oe_g = 1'b1;
                  o_g = s_q.msc[MSC_DR_POL] ? dr_active : ~dr_active;
               end
               OWN_ALARM:
               begin
                  oe_g = 1'b1;
                  o_g = alarm_configuration.level;
               end
               OWN_GENERAL:
               begin
                  oe_g = s_q.gpio[GPIO_DIR_LSB + g];
                  o_g = s_q.gpio[GPIO_LVL_LSB + g];
               end
               default:
               begin
                  oe_g = 1'b0;
                  o_g = 1'b0;
               end
            endcase
         end
         // One driver per bit keeps the two lines apart
         assign pin_oe_nx[g] = oe_g;
         assign pin_o_nx[g] = o_g;
      end
   endgenerate

   // Whole next-state of the system domain
   always_comb
   begin
      s_d = s_q;
      s_d.link_rst = 1'b0;

      // Synchronisers: first stage feeds only the second
      // The toggle crosses alone; its word loads on the same link edge and is stable before the flip lands
      s_d.tog_sync = {s_q.tog_sync[0], link_tog};
      s_d.tog_prev = s_q.tog_sync[1];
      s_d.pin_sync0 = digital_line_i;
      s_d.pin_sync1 = s_q.pin_sync0;

      // Pins are registered so they never glitch on owner changes
      // That costs one cycle of latency on every line change
      s_d.pin_o = pin_o_nx;
      s_d.pin_oe = pin_oe_nx;

      // Sleep timer; config registers are never touched on wake
      // A rewrite restarts the interval; a zero count ends it at once
      if (s_q.sleep)
      begin
         if (s_q.slp_tick == 25'(SLEEP_CYCLES - 1))
         begin
            s_d.slp_tick = '0;
            s_d.slp_left = s_q.slp_left - 8'h01;
            if (s_q.slp_left <= 8'h01)
               s_d.sleep = 1'b0;
         end
         else
         begin
            s_d.slp_tick = s_q.slp_tick + 25'h0000001;
         end
      end

      // Data ready pulse, one per sample, suppressed during sleep
      // Samples arriving inside a pulse are dropped, not queued
      if (dr_active)
         s_d.dr_cnt = s_q.dr_cnt - 16'h0001;
      else if (sample_ready && s_q.msc[MSC_DR_EN] && !s_q.sleep)
         s_d.dr_cnt = DR_WIDTH;

      // Routine completion clears the trigger; a write below still wins
      if (memory_test.done)
         s_d.msc[MSC_MEM_TEST] = 1'b0;
      if (self_test.done)
         s_d.msc[MSC_SELF_TEST] = 1'b0;

      // Decode one received frame
      // Writes touch one byte; masks keep unused bits reading zero
      if (frame_new)
      begin
         if (is_write)
         begin
            case (reg_addr)
               ADDR_AUX_DAC:
                  s_d.dac_buf = merge_byte(s_q.dac_buf, wr_data, hi_byte) & MASK_DAC;
               ADDR_GPIO:
                  s_d.gpio = merge_byte(s_q.gpio, wr_data, hi_byte) & MASK_GPIO;
               ADDR_MSC:
                  s_d.msc = merge_byte(s_q.msc, wr_data, hi_byte) & MASK_MSC;
               ADDR_SMPL:
                  s_d.smpl = merge_byte(s_q.smpl, wr_data, hi_byte) & MASK_SMPL;
               ADDR_SLP:
               begin
                  s_d.slp = merge_byte(s_q.slp, wr_data, hi_byte) & MASK_SLP;
                  if (!hi_byte)
                  begin
                     s_d.sleep = (wr_data != 8'h00);
                     s_d.slp_left = wr_data;
                     s_d.slp_tick = '0;
                  end
               end
               ADDR_GLOB:
               begin
                  // Trigger acts at once, so it never reads back as one
                  if (!hi_byte && wr_data[GLOB_DAC_LATCH])
                     s_d.dac = s_q.dac_buf[DAC_BITS-1:0];
               end
               default:
               begin
                  // Read-only and unmapped words ignore writes
               end
            endcase
         end
         else
         begin
            // Flags clear on read; a fresh result below still sets
            s_d.rd = read_value(reg_addr, s_q);
            if (reg_addr == ADDR_DIAG)
               s_d.diag = RST_DIAG;
         end
      end

      // Test results land after any clear-on-read
      if (memory_test.done)
         s_d.diag[DIAG_MEM_FAIL] = memory_test.fail;
      if (self_test.done)
         s_d.diag[DIAG_SELF_FAIL] = self_test.fail;
   end

   // Single register stage for all system-domain state
   // Synchronous reset; the link side sees it through link_rst
   always_ff @(posedge sys_clk)
   begin
      if (sys_rst)
      begin
         s_q <= '0;
         // Spelled out so the idle value of every output is plain here
         s_q.pin_o <= 2'h0;
         s_q.pin_oe <= 2'h0;
         s_q.dac <= 12'h000;
         s_q.sleep <= 1'b0;
         s_q.dr_cnt <= 16'h0000;
         s_q.rd <= 16'h0000;
         s_q.link_rst <= 1'b1;
         s_q.smpl <= RST_SMPL;
         s_q.slp <= RST_SLP;
         s_q.gpio <= RST_GPIO;
         s_q.msc <= RST_MSC;
         s_q.dac_buf <= RST_DAC;
         s_q.diag <= RST_DIAG;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   // Outputs straight from state
   // Low power follows the register at once; the host must slow its link clock
   assign digital_line_o = s_q.pin_o;
   assign digital_line_oe = s_q.pin_oe;
   assign memory_test_run = s_q.msc[MSC_MEM_TEST];
   assign self_test_run = s_q.msc[MSC_SELF_TEST];
   assign stimulus_negative = s_q.msc[MSC_STIM_NEG];
   assign stimulus_positive = s_q.msc[MSC_STIM_POS];
   assign dac_code = s_q.dac;
   assign low_power_mode = (s_q.smpl[7:0] >= LOW_POWER_MIN);
   assign sleep_mode = s_q.sleep;

endmodule : iopst_ctrl

// ==== testbench/iopst_ctrl_properties.sv ====
`timescale 1ns/100ps

// Pin-level checks on the control block
module iopst_ctrl_chk
   import iopst_pkg::*;
#(
   parameter int unsigned SLEEP_CYCLES = 20,
   parameter logic [15:0] DR_WIDTH = 16'h0010
)
(
   input wire logic sys_clk,
   input wire logic sys_rst,
   input wire logic sample_ready,
   input wire iopst_pkg::iopst_alarm_s alarm_configuration,
   input wire iopst_pkg::iopst_test_s memory_test,
   input wire iopst_pkg::iopst_test_s self_test,
   input wire logic [1:0] digital_line_o,
   input wire logic [1:0] digital_line_oe,
   input wire logic memory_test_run,
   input wire logic self_test_run,
   input wire logic sleep_mode
);
   logic [31:0] slp_q;
   logic [15:0] dr_q;
   logic pend_q;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (sys_rst);

   // Sleep length and time since last line change; pend marks a pulse
   always_ff @(posedge sys_clk)
   begin
      slp_q <= sleep_mode ? slp_q + 32'h1 : 32'h0;
      dr_q <= $changed(digital_line_o) ? 16'h1 : dr_q + 16'h1;
      if (sys_rst)
         pend_q <= 1'b0;
      else if ($changed(digital_line_o))
         pend_q <= $past(sample_ready, 2) & ~pend_q;
   end

   a_dr_width: assert property ($changed(digital_line_o) && pend_q |->
      dr_q >= DR_WIDTH - 16'h1 && dr_q <= DR_WIDTH + 16'h1)
      else $error("ready pulse width wrong");
   a_sleep_len: assert property ($fell(sleep_mode) |->
      slp_q != 0 && slp_q % SLEEP_CYCLES == 0)
      else $error("sleep not a whole count");
   a_sleep_max: assert property (slp_q <= 255 * SLEEP_CYCLES)
      else $error("sleep too long");
   a_mem_clear: assert property (memory_test.done && memory_test_run |->
      ##[1:2] !memory_test_run)
      else $error("memory test bit kept");
   a_mem_hold: assert property (memory_test_run && !memory_test.done &&
      !$past(memory_test.done) |=> memory_test_run)
      else $error("memory test bit lost");
   a_self_clear: assert property (self_test.done && self_test_run |->
      ##[1:2] !self_test_run)
      else $error("self test bit kept");
   a_self_hold: assert property (self_test_run && !self_test.done &&
      !$past(self_test.done) |=> self_test_run)
      else $error("self test bit lost");
   a_line_owner: assert property (alarm_configuration.enable [*3] |->
      digital_line_oe[alarm_configuration.line_select])
      else $error("alarm line not driven");

   c_sleep: cover property ($fell(sleep_mode));
   c_mem: cover property (memory_test.done && memory_test_run);
   c_pulse: cover property ($changed(digital_line_o) && pend_q);
endmodule : iopst_ctrl_chk

bind iopst_ctrl iopst_ctrl_chk #(
   .SLEEP_CYCLES(SLEEP_CYCLES),
   .DR_WIDTH(DR_WIDTH)
) chk_u (
   .sys_clk(sys_clk),
   .sys_rst(sys_rst),
   .sample_ready(sample_ready),
   .alarm_configuration(alarm_configuration),
   .memory_test(memory_test),
   .self_test(self_test),
   .digital_line_o(digital_line_o),
   .digital_line_oe(digital_line_oe),
   .memory_test_run(memory_test_run),
   .self_test_run(self_test_run),
   .sleep_mode(sleep_mode)
);

// ==== testbench/iopst_host_model.sv ====
`timescale 1ns/100ps

// Serial master, mode 3; clock stands high between frames
module iopst_host_model
(
   input wire logic slow,
   input wire logic spi_miso,
   output logic spi_sclk,
   output logic spi_cs_n,
   output logic spi_mosi
);
   realtime half;

   initial
   begin
      spi_sclk = 1'b1;
      spi_cs_n = 1'b1;
      spi_mosi = 1'b0;
   end

   // One frame; reply bit taken just before each rising edge
   task automatic xfer(input logic [15:0] w, output logic [15:0] r);
      half = slow ? 48.0 : 24.0;
      spi_cs_n = 1'b0;
      for (int i = 15; i >= 0; i--)
      begin
         spi_sclk = 1'b0;
         spi_mosi = w[i];
         #(half);
         r[i] = spi_miso;
         spi_sclk = 1'b1;
         #(half);
      end
      spi_cs_n = 1'b1;
      spi_mosi = ~spi_mosi; // No stale bit once released
      #240;
   endtask : xfer
endmodule : iopst_host_model

// ==== testbench/testbench.sv ====
`timescale 1ns/100ps

module testbench;
   import iopst_pkg::*;
   localparam int SC = 20;
   localparam int DW = 16;
   logic sys_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic spi_sclk, spi_cs_n, spi_mosi, spi_miso, sample_ready = 1'b0;
   iopst_alarm_s alarm_configuration = '0;
   iopst_test_s memory_test = '0;
   iopst_test_s self_test = '0;
   logic [1:0] digital_line_i, digital_line_o, digital_line_oe, ext = 2'h0;
   logic memory_test_run, self_test_run, stimulus_negative, stimulus_positive;
   logic [11:0] dac_code;
   logic low_power_mode, sleep_mode;
   logic [15:0] rep;
   int checks = 0;
   int n_mismatch = 0;
   int cyc = 0;
   int w;

   always #10 sys_clk = ~sys_clk;
   // Pin level: the driving party wins, else the outside level
   assign digital_line_i[0] = digital_line_oe[0] === 1'b1 ? digital_line_o[0] : ext[0];
   assign digital_line_i[1] = digital_line_oe[1] === 1'b1 ? digital_line_o[1] : ext[1];

   iopst_ctrl #(.SLEEP_CYCLES(SC), .DR_WIDTH(16'(DW))) dut_u (.sys_clk(sys_clk),
      .sys_rst(sys_rst), .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
      .spi_miso(spi_miso), .sample_ready(sample_ready),
      .alarm_configuration(alarm_configuration), .memory_test(memory_test),
      .self_test(self_test), .digital_line_i(digital_line_i),
      .digital_line_o(digital_line_o), .digital_line_oe(digital_line_oe),
      .memory_test_run(memory_test_run), .self_test_run(self_test_run),
      .stimulus_negative(stimulus_negative), .stimulus_positive(stimulus_positive),
      .dac_code(dac_code), .low_power_mode(low_power_mode), .sleep_mode(sleep_mode));
   iopst_host_model host_u (.slow(low_power_mode), .spi_miso(spi_miso),
      .spi_sclk(spi_sclk), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi));

   task automatic stop_test;
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks++;
      if (got !== exp)
      begin
         n_mismatch++;
         $display("[FAIL] %0t got %h want %h", $time, got, exp);
      end
   endtask : chk

   task automatic wr(input logic [15:0] word);
      host_u.xfer(word, rep);
   endtask : wr

   // Read answer comes back in the following frame
   task automatic rd(input logic [6:0] a, input logic [15:0] exp);
      host_u.xfer({1'b0, a, 8'h00}, rep);
      host_u.xfer(16'h0000, rep);
      chk(rep, exp);
   endtask : rd

   // Sample strobe, then width of the pulse it causes
   task automatic dr_pulse(input int ln, input logic act);
      @(posedge sys_clk) #1 sample_ready = 1'b1;
      @(posedge sys_clk) #1 sample_ready = 1'b0;
      w = 0;
      for (int k = 0; k < 9 && digital_line_o[ln] !== act; k++) @(posedge sys_clk) #1;
      while (digital_line_o[ln] === act && w < 99)
      begin
         @(posedge sys_clk) #1;
         w++;
      end
      chk(16'(w), 16'(DW));
   endtask : dr_pulse

   // Test routine completion strobe with a fail result
   task automatic finish(input logic sel);
      @(posedge sys_clk) #1;
      if (sel)
         self_test = 2'h3;
      else
         memory_test = 2'h3;
      @(posedge sys_clk) #1;
      self_test = '0;
      memory_test = '0;
      repeat (2) @(posedge sys_clk);
      #1;
   endtask : finish

   // Hang guard
   always @(posedge sys_clk)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_mismatch++;
         stop_test();
      end
   end

   initial
   begin
      repeat (10) @(posedge sys_clk);
      #1 sys_rst = 1'b0;
      repeat (4) @(posedge sys_clk);
      rd(ADDR_SMPL, RST_SMPL);
      rd(ADDR_SLP, RST_SLP);
      rd(ADDR_MSC, RST_MSC);
      rd(ADDR_AUX_DAC, RST_DAC);
      rd(7'h20, 16'h0000);
      wr(16'hb607);
      chk(16'(low_power_mode), 16'h0);
      wr(16'hb608);
      chk(16'(low_power_mode), 16'h1);
      rd(ADDR_SMPL, 16'h0008);
      wr(16'hb601);
      wr(16'hba02);
      chk(16'(sleep_mode), 16'h1);
      repeat (2 * SC - 16) @(posedge sys_clk);
      #1 chk(16'(sleep_mode), 16'h1);
      repeat (14) @(posedge sys_clk);
      #1 chk(16'(sleep_mode), 16'h0);
      rd(ADDR_SMPL, 16'h0001);
      rd(ADDR_SLP, 16'h0002);
      ext = 2'h1;
      wr(16'hb302);
      wr(16'hb202);
      chk(16'(digital_line_oe), 16'h2);
      chk(16'(digital_line_o[1]), 16'h1);
      rd(ADDR_GPIO, 16'h0302);
      wr(16'hb404);
      chk(16'(digital_line_oe), 16'h3);
      chk(16'(digital_line_o), 16'h3);
      dr_pulse(0, 1'b0);
      wr(16'hb407);
      chk(16'(digital_line_o[1]), 16'h0);
      dr_pulse(1, 1'b1);
      @(posedge sys_clk) #1 alarm_configuration = 3'b101;
      repeat (3) @(posedge sys_clk);
      #1 chk(16'({digital_line_oe[0], digital_line_o[0]}), 16'h3);
      alarm_configuration = 3'b111;
      repeat (3) @(posedge sys_clk);
      #1 chk(16'(digital_line_o[1]), 16'h0);
      alarm_configuration = '0;
      wr(16'hb400);
      wr(16'hb508);
      chk(16'(memory_test_run), 16'h1);
      finish(1'b0);
      chk(16'(memory_test_run), 16'h0);
      rd(ADDR_DIAG, 16'h0040);
      rd(ADDR_DIAG, 16'h0000);
      wr(16'hb504);
      chk(16'(self_test_run), 16'h1);
      finish(1'b1);
      chk(16'(self_test_run), 16'h0);
      rd(ADDR_MSC, 16'h0000);
      rd(ADDR_DIAG, 16'h0020);
      wr(16'hb502);
      chk(16'({stimulus_negative, stimulus_positive}), 16'h2);
      wr(16'hb501);
      chk(16'({stimulus_negative, stimulus_positive}), 16'h1);
      wr(16'hb500);
      chk(16'({stimulus_negative, stimulus_positive}), 16'h0);
      wr(16'hb0cc);
      wr(16'hb10c);
      chk(16'(dac_code), 16'h0000);
      wr(16'hbe04);
      chk(16'(dac_code), 16'h0ccc);
      rd(ADDR_GLOB, 16'h0000);
      rd(ADDR_AUX_DAC, 16'h0ccc);
      stop_test();
   end
endmodule : testbench
